// ===== rfq_addr_gen.sv
// Registered physical address former: queue base plus index scaled to dwords.
`timescale 1ns/1ps
`default_nettype none
module rfq_addr_gen #(
  parameter int DW = 32,
  parameter int IW = 16,
  parameter int SH = 2
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [DW-1:0] i_base,
  input wire logic [IW-1:0] i_index,
  output logic [DW-1:0] o_addr
);
  logic [DW-1:0] next_addr;
  logic [DW-1:0] addr;

  always_comb begin
    next_addr = i_base + (DW'(i_index) << SH);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      addr <= '0;
    end else begin
      addr <= next_addr;
    end
  end

  assign o_addr = addr;
endmodule : rfq_addr_gen
`default_nettype wire

// ===== rfq_dma_model.sv
// Behavioural model of the receive DMA engine that takes free queue elements.
`timescale 1ns/1ps
`default_nettype none
module rfq_dma_model (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_go,
  output logic o_consume
);
  logic next_consume;
  // Each request cycle on i_go gives one consume cycle one clock later, empty queue or not.
  always_comb begin
    next_consume = i_go;
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_consume <= 1'b0;
    end else begin
      o_consume <= next_consume;
    end
  end
endmodule : rfq_dma_model
`default_nettype wire

// ===== rfq_pkg.sv
// Package of register map, field layout and reset constants for the receive free queue registers.
package rfq_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 16;
  localparam int IDX_SHIFT = 2;
  localparam logic [ADDR_W-1:0] OFF_BASE_LOW = 12'h290;
  localparam logic [ADDR_W-1:0] OFF_BASE_HIGH = 12'h294;
  localparam logic [ADDR_W-1:0] OFF_START = 12'h298;
  localparam logic [ADDR_W-1:0] OFF_WRITE = 12'h29C;
  localparam logic [ADDR_W-1:0] OFF_READ = 12'h2A0;
  localparam logic [ADDR_W-1:0] OFF_END = 12'h2A4;
  localparam logic [IDX_W-1:0] RST_IDX = 16'h0000;
  localparam logic [DATA_W-1:0] RST_BASE = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rfq_pkg

// ===== rfq_regs.sv
// Receive queue base and large-buffer free queue index registers behind an AXI4-Lite slave.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - A write to the lower base half is held and the base changes only when the upper half is written.
// - One base serves all receive descriptor reference queues.
// - Every queue element address is the base plus an index times four.
// - The start address is the base plus the start index times four.
// - The write address is the base plus the write pointer times four.
// - The read address is the base plus the read pointer times four.
// - The end index register can be written and read back.
// - The end address is the base plus the end index times four.
// - The lower base half waits in a holding register until the upper half is written.
module rfq_regs (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [rfq_pkg::ADDR_W-1:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [rfq_pkg::DATA_W-1:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [rfq_pkg::ADDR_W-1:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [rfq_pkg::DATA_W-1:0] O_RDATA,
  output logic [1:0] O_RRESP,
  input wire logic I_CONSUME,
  output logic [rfq_pkg::DATA_W-1:0] O_QUEUE_BASE,
  output logic [rfq_pkg::DATA_W-1:0] O_START_ADDR,
  output logic [rfq_pkg::DATA_W-1:0] O_WRITE_ADDR,
  output logic [rfq_pkg::DATA_W-1:0] O_READ_ADDR,
  output logic [rfq_pkg::DATA_W-1:0] O_END_ADDR,
  output logic O_QUEUE_EMPTY
);
  import rfq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Bus state.
  logic awready, wready, bvalid, arready, rvalid, aw_got, w_got;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic next_aw_got, next_w_got;
  logic [1:0] bresp, rresp, next_bresp, next_rresp;
  logic [ADDR_W-1:0] waddr, next_waddr;
  logic [DATA_W-1:0] wdata, next_wdata, rdata, next_rdata;
  logic [3:0] wstrb, next_wstrb;
  logic aw_fire, w_fire, ar_fire, wr_do;

  // Register state.
  logic [IDX_W-1:0] base_hold, next_base_hold;
  logic [DATA_W-1:0] queue_base, next_queue_base;
  logic [IDX_W-1:0] start_index, next_start_index;
  logic [IDX_W-1:0] write_pointer, next_write_pointer;
  logic [IDX_W-1:0] read_pointer, next_read_pointer;
  logic [IDX_W-1:0] end_index, next_end_index;
  logic empty, next_empty;
  logic [IDX_W-1:0] wmerged;
  logic [IDX_W-1:0] wr_old;
  logic wr_ok, sw_rd_write, advance;

  assign aw_fire = I_AWVALID && awready;
  assign w_fire = I_WVALID && wready;
  assign ar_fire = I_ARVALID && arready;
  assign wr_do = aw_got && w_got && !bvalid;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Write and read channels.
  always_comb begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_waddr = waddr;
    next_wdata = wdata;
    next_wstrb = wstrb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (aw_fire) begin
      next_aw_got = 1'b1;
      next_waddr = I_AWADDR;
    end
    if (w_fire) begin
      next_w_got = 1'b1;
      next_wdata = I_WDATA;
      next_wstrb = I_WSTRB;
    end
    if (wr_do) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && I_BREADY) begin
      next_bvalid = 1'b0;
    end
    next_awready = !next_aw_got && !next_bvalid;
    next_wready = !next_w_got && !next_bvalid;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (ar_fire) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      case (I_ARADDR)
        OFF_BASE_LOW: next_rdata = {16'h0000, base_hold};
        OFF_BASE_HIGH: next_rdata = {16'h0000, queue_base[31:16]};
        OFF_START: next_rdata = {16'h0000, start_index};
        OFF_WRITE: next_rdata = {16'h0000, write_pointer};
        OFF_READ: next_rdata = {16'h0000, read_pointer};
        OFF_END: next_rdata = {16'h0000, end_index};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end else if (rvalid && I_RREADY) begin
      next_rvalid = 1'b0;
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      waddr <= '0;
      wdata <= '0;
      wstrb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      awready <= 1'b0;
      wready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
      arready <= 1'b0;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      waddr <= next_waddr;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      awready <= next_awready;
      wready <= next_wready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      arready <= next_arready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Register file and read pointer advance.
  always_comb begin
    next_base_hold = base_hold;
    next_queue_base = queue_base;
    next_start_index = start_index;
    next_write_pointer = write_pointer;
    next_read_pointer = read_pointer;
    next_end_index = end_index;
    wr_ok = 1'b1;
    sw_rd_write = 1'b0;
    case (waddr)
      OFF_BASE_LOW: wr_old = base_hold;
      OFF_BASE_HIGH: wr_old = queue_base[31:16];
      OFF_START: wr_old = start_index;
      OFF_WRITE: wr_old = write_pointer;
      OFF_READ: wr_old = read_pointer;
      OFF_END: wr_old = end_index;
      default: begin
        wr_old = 16'h0000;
        wr_ok = 1'b0;
      end
    endcase
    wmerged[7:0] = wstrb[0] ? wdata[7:0] : wr_old[7:0];
    wmerged[15:8] = wstrb[1] ? wdata[15:8] : wr_old[15:8];
    if (wr_do) begin
      case (waddr)
        OFF_BASE_LOW: next_base_hold = wmerged;
        OFF_BASE_HIGH: next_queue_base = {wmerged, base_hold};
        OFF_START: next_start_index = wmerged;
        OFF_WRITE: next_write_pointer = wmerged;
        OFF_READ: begin
          next_read_pointer = wmerged;
          sw_rd_write = 1'b1;
        end
        OFF_END: next_end_index = wmerged;
        default: next_base_hold = base_hold;
      endcase
    end
    advance = I_CONSUME && !empty && !sw_rd_write;
    if (advance) begin
      next_read_pointer = (read_pointer == end_index) ? start_index
                          : IDX_W'(read_pointer + 16'h0001);
    end
    next_empty = (next_read_pointer == next_write_pointer);
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      base_hold <= RST_IDX;
      queue_base <= RST_BASE;
      start_index <= RST_IDX;
      write_pointer <= RST_IDX;
      read_pointer <= RST_IDX;
      end_index <= RST_IDX;
      empty <= 1'b1;
    end else begin
      base_hold <= next_base_hold;
      queue_base <= next_queue_base;
      start_index <= next_start_index;
      write_pointer <= next_write_pointer;
      read_pointer <= next_read_pointer;
      end_index <= next_end_index;
      empty <= next_empty;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Address formers sharing the one queue base.
  rfq_addr_gen #(.DW(DATA_W), .IW(IDX_W), .SH(IDX_SHIFT)) u_start (
    .i_clk(I_CLK), .i_rst_b(I_RST_B), .i_base(queue_base), .i_index(start_index),
    .o_addr(O_START_ADDR));
  rfq_addr_gen #(.DW(DATA_W), .IW(IDX_W), .SH(IDX_SHIFT)) u_write (
    .i_clk(I_CLK), .i_rst_b(I_RST_B), .i_base(queue_base), .i_index(write_pointer),
    .o_addr(O_WRITE_ADDR));
  rfq_addr_gen #(.DW(DATA_W), .IW(IDX_W), .SH(IDX_SHIFT)) u_read (
    .i_clk(I_CLK), .i_rst_b(I_RST_B), .i_base(queue_base), .i_index(read_pointer),
    .o_addr(O_READ_ADDR));
  rfq_addr_gen #(.DW(DATA_W), .IW(IDX_W), .SH(IDX_SHIFT)) u_end (
    .i_clk(I_CLK), .i_rst_b(I_RST_B), .i_base(queue_base), .i_index(end_index),
    .o_addr(O_END_ADDR));

  assign O_AWREADY = awready;
  assign O_WREADY = wready;
  assign O_BVALID = bvalid;
  assign O_BRESP = bresp;
  assign O_ARREADY = arready;
  assign O_RVALID = rvalid;
  assign O_RDATA = rdata;
  assign O_RRESP = rresp;
  assign O_QUEUE_BASE = queue_base;
  assign O_QUEUE_EMPTY = empty;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_base_only_on_high;
    @(posedge I_CLK) disable iff (!I_RST_B)
    !(wr_do && waddr == OFF_BASE_HIGH) |=> $stable(queue_base);
  endproperty
  a_base_only_on_high: assert property (p_base_only_on_high)
    else $error("Queue base changed without an upper half write.");

  property p_low_held;
    @(posedge I_CLK) disable iff (!I_RST_B)
    wr_do && waddr == OFF_BASE_LOW && wstrb == 4'hF
    |=> base_hold == $past(wdata[15:0]) && $stable(queue_base);
  endproperty
  a_low_held: assert property (p_low_held)
    else $error("Lower base half not held.");

  property p_common_base;
    @(posedge I_CLK) disable iff (!I_RST_B)
    $stable(queue_base) && $stable(start_index) && $stable(end_index)
    |=> O_END_ADDR - O_START_ADDR == (32'($past(end_index)) << 2) - (32'($past(start_index)) << 2);
  endproperty
  a_common_base: assert property (p_common_base)
    else $error("Start and end addresses do not share a base.");

  property p_low_bits;
    @(posedge I_CLK) disable iff (!I_RST_B)
    ##1 O_WRITE_ADDR[1:0] == $past(queue_base[1:0], 1);
  endproperty
  a_low_bits: assert property (p_low_bits)
    else $error("Element address low bits differ from base.");

  property p_start_addr;
    @(posedge I_CLK) disable iff (!I_RST_B)
    1'b1 |=> O_START_ADDR == $past(queue_base) + (32'($past(start_index)) << 2);
  endproperty
  a_start_addr: assert property (p_start_addr)
    else $error("Start address wrong.");

  property p_write_addr;
    @(posedge I_CLK) disable iff (!I_RST_B)
    1'b1 |=> O_WRITE_ADDR == $past(queue_base) + (32'($past(write_pointer)) << 2);
  endproperty
  a_write_addr: assert property (p_write_addr)
    else $error("Write address wrong.");

  property p_read_addr;
    @(posedge I_CLK) disable iff (!I_RST_B)
    advance |=> ##1 O_READ_ADDR == $past(queue_base) + (32'($past(read_pointer)) << 2);
  endproperty
  a_read_addr: assert property (p_read_addr)
    else $error("Read address wrong after advance.");

  property p_end_rw;
    @(posedge I_CLK) disable iff (!I_RST_B)
    wr_do && waddr == OFF_END && wstrb == 4'hF |=> end_index == $past(wdata[15:0]);
  endproperty
  a_end_rw: assert property (p_end_rw)
    else $error("End index not written.");

  property p_end_addr;
    @(posedge I_CLK) disable iff (!I_RST_B)
    $changed(end_index) |=> O_END_ADDR == $past(queue_base) + (32'($past(end_index)) << 2);
  endproperty
  a_end_addr: assert property (p_end_addr)
    else $error("End address wrong.");

  property p_wrap;
    @(posedge I_CLK) disable iff (!I_RST_B)
    advance && read_pointer == end_index |=> read_pointer == $past(start_index);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("Read pointer did not wrap to start.");
endmodule : rfq_regs
`default_nettype wire

// ===== rx_free_queue_pointer_regs_test.sv
// Self-checking testbench for the receive free queue pointer registers.
`timescale 1ns/1ps
`default_nettype none
module rx_free_queue_pointer_regs_test;
  import rfq_pkg::*;
  logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready, go, consume;
  logic awready, wready, bvalid, arready, rvalid, empty;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, qbase, a_start, a_write, a_read, a_end, rd;
  logic [1:0] bresp, rresp, resp;
  logic [3:0] wstrb;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  localparam logic [DATA_W-1:0] BASE = 32'h1234_5678;

  rfq_regs rfq_regs_i (.I_CLK(clk), .I_RST_B(rst_b), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_AWADDR(awaddr), .I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata),
    .I_WSTRB(wstrb), .O_BVALID(bvalid), .I_BREADY(bready), .O_BRESP(bresp),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr), .O_RVALID(rvalid),
    .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp), .I_CONSUME(consume),
    .O_QUEUE_BASE(qbase), .O_START_ADDR(a_start), .O_WRITE_ADDR(a_write),
    .O_READ_ADDR(a_read), .O_END_ADDR(a_end), .O_QUEUE_EMPTY(empty));
  rfq_dma_model rfq_dma_model_i (.i_clk(clk), .i_rst_b(rst_b), .i_go(go), .o_consume(consume));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [DATA_W-1:0] exp_addr(input logic [IDX_W-1:0] idx);
    return BASE + ({16'h0000, idx} << IDX_SHIFT);
  endfunction : exp_addr
  // Write address and data are offered together and released as each is taken.
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        input logic [3:0] s = 4'hF);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  // Registers land with the response, addresses one cycle after them.
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic pulse();
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [ADDR_W-1:0] offs [6] = '{OFF_BASE_LOW, OFF_BASE_HIGH, OFF_START, OFF_WRITE,
                                    OFF_READ, OFF_END};
    foreach (offs[k]) begin
      axi_rd(offs[k]);
      check("reset value", rd, RST_BASE);
      check("reset rresp", {30'h0, resp}, {30'h0, RESP_OKAY});
    end
    check("reset empty", {31'h0, empty}, 32'h1);
  endtask : t_reset
  task automatic t_base();
    axi_wr(OFF_BASE_LOW, 32'hFFFF_5678);
    check("low bresp", {30'h0, resp}, {30'h0, RESP_OKAY});
    settle();
    check("base held", qbase, RST_BASE);
    axi_rd(OFF_BASE_LOW);
    check("holding", rd, 32'h0000_5678);
    axi_wr(OFF_BASE_HIGH, {16'h0000, BASE[31:16]});
    settle();
    check("base", qbase, BASE);
    axi_rd(OFF_BASE_HIGH);
    check("base high", rd, {16'h0000, BASE[31:16]});
  endtask : t_base
  task automatic t_index();
    logic [ADDR_W-1:0] offs [4] = '{OFF_START, OFF_WRITE, OFF_READ, OFF_END};
    logic [IDX_W-1:0] vals [4] = '{16'h0010, 16'hFFFF, 16'h8001, 16'h0012};
    foreach (offs[k]) axi_wr(offs[k], {16'hA5A5, vals[k]});
    settle();
    check("start addr", a_start, exp_addr(vals[0]));
    check("write addr", a_write, exp_addr(vals[1]));
    check("read addr", a_read, exp_addr(vals[2]));
    check("end addr", a_end, exp_addr(vals[3]));
    check("not empty", {31'h0, empty}, 32'h0);
    foreach (offs[k]) begin
      axi_rd(offs[k]);
      check("index readback", rd, {16'h0000, vals[k]});
    end
  endtask : t_index
  task automatic t_unmapped();
    axi_wr(12'h2A8, 32'h0000_FFFF);
    check("unmapped bresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_rd(12'h2A8);
    check("unmapped rdata", rd, 32'h0);
    check("unmapped rresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_rd(OFF_END);
    check("end kept", rd, 32'h0000_0012);
    axi_wr(OFF_END, 32'h0000_5601, 4'h1);
    axi_wr(OFF_END, 32'h0000_3456, 4'h2);
    axi_rd(OFF_END);
    check("end lanes", rd, 32'h0000_3401);
    axi_wr(OFF_END, 32'h0000_0012);
  endtask : t_unmapped
  task automatic t_wrap();
    axi_wr(OFF_WRITE, 32'h0000_0010);
    axi_wr(OFF_READ, 32'h0000_0011);
    pulse();
    check("read step", a_read, exp_addr(16'h0012));
    pulse();
    check("read wrap", a_read, exp_addr(16'h0010));
    check("empty wrap", {31'h0, empty}, 32'h1);
    pulse();
    check("start same base", a_start, exp_addr(16'h0010));
    check("read held", a_read, exp_addr(16'h0010));
    axi_rd(OFF_READ);
    check("empty ignored", rd, 32'h0000_0010);
  endtask : t_wrap

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    go = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_base();
    t_index();
    t_unmapped();
    t_wrap();
    tally_and_finish();
  end
endmodule : rx_free_queue_pointer_regs_test
`default_nettype wire
